// File: rtl/emcr_ahb_port.sv
// Purpose: AHB-Lite slave front end of the configuration bank
// Assumes: Single word transfers; response always OKAY
// Notes:   Writes take no wait state, reads take one
`timescale 1ns/1ps
`default_nettype none
module emcr_ahb_port
   import emcr_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic      [31:0]       hrdata,
   output emcr_wr_s               wr,
   output logic      [IDX_W-1:0]  rd_idx,
   output logic                   rd_hit,
   input  wire logic [DATA_W-1:0] rd_value
);

   logic             take;
   logic             legal;
   logic             wr_pend;
   logic             rd_pend;
   logic             hit_q;
   logic [IDX_W-1:0] idx_q;

   assign take  = hsel && hready && htrans[1];
   assign legal = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0)
                  && (haddr[31:ADDR_IDX_MSB+1] == '0);

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         hit_q   <= 1'b0;
         idx_q   <= '0;
      end else begin
         if (take) begin
            wr_pend <= hwrite;
            rd_pend <= !hwrite;
            hit_q   <= legal
                       && (haddr[ADDR_IDX_MSB:ADDR_IDX_LSB] <= IDX_LAST);
            idx_q   <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
         end else if (hreadyout) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
         end else begin
            rd_pend <= 1'b0;
         end
      end
   end

   // Read wait state: data registered in the first data-phase cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hrdata    <= '0;
      end else if (take && !hwrite) begin
         hreadyout <= 1'b0;
      end else if (rd_pend) begin
         hreadyout <= 1'b1;
         hrdata    <= hit_q ? rd_value : '0;
      end
   end

   assign hresp    = HRESP_OKAY;
   assign wr.en    = wr_pend && hit_q;
   assign wr.idx   = idx_q;
   assign wr.data  = hwdata;
   assign rd_idx   = idx_q;
   assign rd_hit   = hit_q;

endmodule
`default_nettype wire

// File: rtl/emcr_field_reg.sv
// Purpose: One configuration field, writable or fixed at its reset value
// Assumes: Write strobe and data from logic on the same clock
// Notes:   A fixed field ignores every write
`timescale 1ns/1ps
`default_nettype none
module emcr_field_reg #(
   parameter int unsigned   W        = 32,
   parameter logic [W-1:0]  RESET    = '0,
   parameter bit            WRITABLE = 1'b1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         we,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= RESET;
      end else if (we && WRITABLE) begin
         q <= d;
      end
   end

endmodule
`default_nettype wire

// File: rtl/emcr_pkg.sv
// Purpose: Shared constants and types of the MAC base configuration bank
// Assumes: Registers are one 32-bit word each, byte address = 4 * index
// Notes:   Indices are dword offsets, not byte addresses
package emcr_pkg;

   localparam int unsigned DATA_W       = 32;
   localparam int unsigned IDX_W        = 8;

   localparam logic [IDX_W-1:0] IDX_VERSION   = 8'h00;
   localparam logic [IDX_W-1:0] IDX_SCRATCH   = 8'h01;
   localparam logic [IDX_W-1:0] IDX_CONTROL   = 8'h02;
   localparam logic [IDX_W-1:0] IDX_ADDR_LOW  = 8'h03;
   localparam logic [IDX_W-1:0] IDX_ADDR_HIGH = 8'h04;
   localparam logic [IDX_W-1:0] IDX_FRM_LEN   = 8'h05;
   localparam logic [IDX_W-1:0] IDX_PAUSE_Q   = 8'h06;
   localparam logic [IDX_W-1:0] IDX_RX_SEMPTY = 8'h07;
   localparam logic [IDX_W-1:0] IDX_LAST      = 8'h07;

   // Byte address bits that select the word index
   localparam int unsigned ADDR_IDX_LSB = 2;
   localparam int unsigned ADDR_IDX_MSB = ADDR_IDX_LSB + IDX_W - 1;

   // Control register fields
   localparam int unsigned CTL_TX_PATH_ENABLE_BIT = 0;
   localparam int unsigned CTL_RX_PATH_ENABLE_BIT = 1;
   localparam int unsigned CTL_PROMIS_BIT = 4;
   localparam int unsigned CTL_SW_RST_BIT = 13;

   // Field widths and reset values
   localparam int unsigned LEN_W         = 16;
   localparam int unsigned ADDR_HIGH_W   = 16;
   localparam logic [15:0] FRM_LEN_RESET = 16'h05ee;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
   localparam logic [15:0] HALF_RESET    = 16'h0000;
   localparam int unsigned SEMPTY_MARGIN = 16;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_IDLE   = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef struct packed {
      logic              en;
      logic [IDX_W-1:0]  idx;
      logic [DATA_W-1:0] data;
   } emcr_wr_s;

   typedef struct packed {
      logic              tx_path_enable;
      logic              rx_path_enable;
      logic              accept_all_frames;
      logic [47:0]       station_addr;
      logic [LEN_W-1:0]  max_frame_len;
      logic [LEN_W-1:0]  pause_quanta;
      logic [DATA_W-1:0] rx_section_empty_level;
   } emcr_cfg_s;

endpackage

// File: rtl/emcr_regs.sv
// Purpose: Base configuration register bank of an Ethernet MAC
// Assumes: One clock; AHB-Lite register access; MAC logic on hclk
// Notes:   Unmapped or reserved words read zero and ignore writes
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Software reset clears only the transmit and receive enables.
// - Version word: IP version low half, customer revision high half.
// - Customer revision is a build parameter defaulting to zero.
// - Scratch word at index one, resets zero, absent in small variants.
// - First four address bytes sit reversed in the low address word.
// - Received lengths checked against 16-bit limit, reset 1518.
// - Small variants fix the frame length limit at 1518, read-only.
// - Pause frames carry the pause quanta value when congested.
// - Small variants never send pause frames.
// - Small variants fix section-empty at FIFO depth minus sixteen.
module emcr_regs
   import emcr_pkg::*;
#(
   parameter bit          SMALL_MAC               = 1'b0,
   parameter logic [15:0] IP_VERSION              = 16'h0001,
   parameter logic [15:0] customer_revision_param = 16'h0000,
   parameter int unsigned FIFO_DEPTH              = 2048
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic      [31:0]       hrdata,
   output emcr_cfg_s              cfg,
   output logic                   mac_running,
   input  wire logic              rx_len_valid,
   input  wire logic [LEN_W-1:0]  rx_len,
   output logic                   rx_len_exceeded,
   input  wire logic              congested,
   input  wire logic              pause_ack,
   output logic                   pause_req,
   output logic      [LEN_W-1:0]  pause_frame_quanta
);

   localparam logic [DATA_W-1:0] SEMPTY_FIXED =
      DATA_W'(FIFO_DEPTH - SEMPTY_MARGIN);
   localparam logic [DATA_W-1:0] SEMPTY_RESET =
      SMALL_MAC ? SEMPTY_FIXED : WORD_RESET;

   emcr_wr_s          wr;
   logic [IDX_W-1:0]  rd_idx;
   logic              rd_hit;
   logic [DATA_W-1:0] rd_value;

   logic [DATA_W-1:0]      control;
   logic [DATA_W-1:0]      scratch_word;
   logic [DATA_W-1:0]      station_addr_low;
   logic [ADDR_HIGH_W-1:0] station_addr_high;
   logic [LEN_W-1:0]       max_frame_bytes;
   logic [LEN_W-1:0]       pause_quanta_value;
   logic [DATA_W-1:0]      rx_fifo_section_empty_level;
   logic                   congested_q;

   emcr_ahb_port u_port (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .wr        (wr),
      .rd_idx    (rd_idx),
      .rd_hit    (rd_hit),
      .rd_value  (rd_value)
   );

   // Control word; the soft reset bit self-clears and reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control <= CONTROL_RESET;
      end else if (wr.en && wr.idx == IDX_CONTROL) begin
         control <= wr.data;
         control[CTL_SW_RST_BIT] <= 1'b0;
         if (wr.data[CTL_SW_RST_BIT]) begin
            control[CTL_TX_PATH_ENABLE_BIT] <= 1'b0;
            control[CTL_RX_PATH_ENABLE_BIT] <= 1'b0;
         end
      end
   end

   emcr_field_reg #(
      .W        (DATA_W),
      .RESET    (WORD_RESET),
      .WRITABLE (!SMALL_MAC)
   ) u_scratch (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (wr.en && wr.idx == IDX_SCRATCH),
      .d       (wr.data),
      .q       (scratch_word)
   );

   emcr_field_reg #(
      .W        (DATA_W),
      .RESET    (WORD_RESET),
      .WRITABLE (1'b1)
   ) u_addr_low (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (wr.en && wr.idx == IDX_ADDR_LOW),
      .d       (wr.data),
      .q       (station_addr_low)
   );

   emcr_field_reg #(
      .W        (ADDR_HIGH_W),
      .RESET    (HALF_RESET),
      .WRITABLE (1'b1)
   ) u_addr_high (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (wr.en && wr.idx == IDX_ADDR_HIGH),
      .d       (wr.data[ADDR_HIGH_W-1:0]),
      .q       (station_addr_high)
   );

   emcr_field_reg #(
      .W        (LEN_W),
      .RESET    (FRM_LEN_RESET),
      .WRITABLE (!SMALL_MAC)
   ) u_frm_len (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (wr.en && wr.idx == IDX_FRM_LEN),
      .d       (wr.data[LEN_W-1:0]),
      .q       (max_frame_bytes)
   );

   emcr_field_reg #(
      .W        (LEN_W),
      .RESET    (HALF_RESET),
      .WRITABLE (1'b1)
   ) u_pause_q (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (wr.en && wr.idx == IDX_PAUSE_Q),
      .d       (wr.data[LEN_W-1:0]),
      .q       (pause_quanta_value)
   );

   emcr_field_reg #(
      .W        (DATA_W),
      .RESET    (SEMPTY_RESET),
      .WRITABLE (!SMALL_MAC)
   ) u_rx_sempty (
      .hclk    (hclk),
      .hresetn (hresetn),
      .we      (wr.en && wr.idx == IDX_RX_SEMPTY),
      .d       (wr.data),
      .q       (rx_fifo_section_empty_level)
   );

   // Read multiplexer
   always_comb begin
      rd_value = '0;
      if (rd_hit) begin
         unique case (rd_idx)
            IDX_VERSION:   rd_value = {customer_revision_param,
                                       IP_VERSION};
            IDX_SCRATCH:   rd_value = scratch_word;
            IDX_CONTROL:   rd_value = control;
            IDX_ADDR_LOW:  rd_value = station_addr_low;
            IDX_ADDR_HIGH: rd_value = {16'h0000, station_addr_high};
            IDX_FRM_LEN:   rd_value = {16'h0000, max_frame_bytes};
            IDX_PAUSE_Q:   rd_value = {16'h0000,
                                       pause_quanta_value};
            IDX_RX_SEMPTY: rd_value = rx_fifo_section_empty_level;
            default:       rd_value = '0;
         endcase
      end
   end

   // Configuration towards the MAC; first address byte in the top byte
   assign cfg.tx_path_enable    = control[CTL_TX_PATH_ENABLE_BIT];
   assign cfg.rx_path_enable    = control[CTL_RX_PATH_ENABLE_BIT];
   assign cfg.accept_all_frames = control[CTL_PROMIS_BIT];
   assign cfg.station_addr      = {station_addr_low[7:0],
                                   station_addr_low[15:8],
                                   station_addr_low[23:16],
                                   station_addr_low[31:24],
                                   station_addr_high[7:0],
                                   station_addr_high[15:8]};
   assign cfg.max_frame_len          = max_frame_bytes;
   assign cfg.pause_quanta           = pause_quanta_value;
   assign cfg.rx_section_empty_level = rx_fifo_section_empty_level;

   assign mac_running = control[CTL_TX_PATH_ENABLE_BIT]
                        && control[CTL_RX_PATH_ENABLE_BIT];

   // Receive length check
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_len_exceeded <= 1'b0;
      end else begin
         rx_len_exceeded <= mac_running && rx_len_valid
                            && (rx_len > max_frame_bytes);
      end
   end

   // Pause frame request on rising congestion, quanta latched with it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         congested_q        <= 1'b0;
         pause_req          <= 1'b0;
         pause_frame_quanta <= '0;
      end else begin
         congested_q <= congested;
         if (SMALL_MAC || !mac_running) begin
            pause_req <= 1'b0;
         end else if (congested && !congested_q) begin
            pause_req          <= 1'b1;
            pause_frame_quanta <= pause_quanta_value;
         end else if (pause_ack) begin
            pause_req <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// File: test/emcr_regs_checker.sv
// Purpose: Timing checks on the ports of the configuration bank
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into every emcr_regs instance
`timescale 1ns/1ps
`default_nettype none
module emcr_regs_checker
   import emcr_pkg::*;
#(
   parameter bit          SMALL_MAC               = 1'b0,
   parameter logic [15:0] IP_VERSION              = 16'h0001,
   parameter logic [15:0] customer_revision_param = 16'h0000
) (
   input wire logic             hclk,
   input wire logic             hresetn,
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [2:0]       hsize,
   input wire logic             hready,
   input wire logic [31:0]      hwdata,
   input wire logic             hreadyout,
   input wire logic [31:0]      hrdata,
   input wire emcr_cfg_s        cfg,
   input wire logic             mac_running,
   input wire logic             rx_len_valid,
   input wire logic [LEN_W-1:0] rx_len,
   input wire logic             rx_len_exceeded,
   input wire logic             congested,
   input wire logic             pause_ack,
   input wire logic             pause_req,
   input wire logic [LEN_W-1:0] pause_frame_quanta
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic go = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
   wire logic rd = go & !hwrite;
   wire logic wr = go & hwrite;
   wire logic big = rx_len_valid & mac_running & (rx_len > cfg.max_frame_len);
   a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout)
      else $error("read wait is not one cycle");
   a_version_word: assert property (rd && haddr == 32'h0 |=> ##1
      hrdata == {customer_revision_param, IP_VERSION})
      else $error("version word wrong");
   a_upper_zero: assert property (rd && (haddr == 32'h14 ||
      haddr == 32'h18) |=> ##1 hrdata[31:16] == 16'h0)
      else $error("upper half not zero");
   a_sw_reset: assert property (wr && haddr == 32'h8 ##1
      hwdata[CTL_SW_RST_BIT] |=> !cfg.tx_path_enable && !cfg.rx_path_enable
      && cfg.accept_all_frames == $past(hwdata[CTL_PROMIS_BIT]))
      else $error("software reset wrong");
   a_run_and: assert property (mac_running ==
      (cfg.tx_path_enable & cfg.rx_path_enable))
      else $error("running flag wrong");
   a_len_flag: assert property (big |=> rx_len_exceeded)
      else $error("long frame not flagged");
   a_len_quiet: assert property (!big |=> !rx_len_exceeded)
      else $error("frame flagged wrongly");
   a_pause_set: assert property (!SMALL_MAC && $rose(congested) &&
      mac_running |=> pause_req && pause_frame_quanta == $past(cfg.pause_quanta))
      else $error("pause request wrong");
   a_pause_ack: assert property (pause_ack && !$rose(congested)
      |=> !pause_req)
      else $error("pause not cleared");
endmodule
bind emcr_regs emcr_regs_checker #(.SMALL_MAC(SMALL_MAC),
   .IP_VERSION(IP_VERSION), .customer_revision_param(customer_revision_param))
   u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
   .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .cfg(cfg),
   .mac_running(mac_running), .rx_len_valid(rx_len_valid), .rx_len(rx_len),
   .rx_len_exceeded(rx_len_exceeded), .congested(congested),
   .pause_ack(pause_ack), .pause_req(pause_req),
   .pause_frame_quanta(pause_frame_quanta));
`default_nettype wire

// File: test/tb.sv
// Purpose: Self-checking bench of the configuration bank
// Assumes: Default full variant, AHB-Lite single word transfers
// Notes:   Register model m is compared at every read and configuration check
`timescale 1ns/1ps
`default_nettype none
module tb;
   import emcr_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [15:0] rx_len = 0, pause_frame_quanta;
   logic        rx_len_valid = 0, congested = 0, pause_ack = 0;
   logic        hreadyout, hresp, mac_running, rx_len_exceeded, pause_req;
   emcr_cfg_s   cfg;
   int unsigned m [9];
   int          miscompares = 0, samples_checked = 0;
   always #20 hclk = ~hclk;
   emcr_regs #(.customer_revision_param(16'h5a3c)) DUT (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg(cfg),
      .mac_running(mac_running), .rx_len_valid(rx_len_valid),
      .rx_len(rx_len), .rx_len_exceeded(rx_len_exceeded),
      .congested(congested), .pause_ack(pause_ack), .pause_req(pause_req),
      .pause_frame_quanta(pause_frame_quanta));
   task automatic chk(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input bit w, input int i, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= 32'(i * 4);
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= HTRANS_IDLE;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic rdchk(input int i);
      logic [31:0] r;
      bus(1'b0, i, 32'h0, r);
      chk(r, m[i]);
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask
   task automatic mwr(input int i, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, i, d, r);
      if (i == 2)
         m[2] = d & (d[13] ? 32'hffff_dffc : 32'hffff_dfff);
      else if (i >= 4 && i <= 6)
         m[i] = d & 32'h0000_ffff;
      else if (i != 0 && i != 8)
         m[i] = d;
   endtask
   task automatic settle(input bit e);
      @(negedge hclk);
      chk({31'h0, pause_req}, {31'h0, e});
      @(posedge hclk);
   endtask
   task automatic cfgchk;
      @(negedge hclk);
      chk({m[3][7:0], m[3][15:8], m[3][23:16], m[3][31:24]},
          cfg.station_addr[47:16]);
      chk({16'h0, m[4][7:0], m[4][15:8]}, {16'h0, cfg.station_addr[15:0]});
      chk({16'h0, cfg.max_frame_len}, m[5]);
      chk({28'h0, cfg.tx_path_enable, cfg.rx_path_enable,
          cfg.accept_all_frames, mac_running},
          {28'h0, m[2][0], m[2][1], m[2][4], m[2][0] & m[2][1]});
      chk(cfg.rx_section_empty_level, m[7]);
      @(posedge hclk);
   endtask
   task automatic rxlen(input logic [15:0] n, input bit e);
      rx_len <= n;
      rx_len_valid <= 1'b1;
      @(posedge hclk);
      rx_len_valid <= 1'b0;
      @(negedge hclk);
      chk({31'h0, rx_len_exceeded}, {31'h0, e});
      @(posedge hclk);
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #400000;
      miscompares++;
      results();
   end
   initial begin
      int          i;
      logic [15:0] n;
      void'($urandom(32'hfdfbbad7));
      m = '{32'h5a3c_0001, 0, 0, 0, 0, 32'h5ee, 0, 0, 0};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (i = 0; i < 9; i++) rdchk(i);
      cfgchk();
      $display("test reset_values done");
      for (int k = 0; k < 40; k++) begin
         i = $urandom_range(8, 0);
         mwr(i, $urandom);
         rdchk(i);
         cfgchk();
      end
      $display("test random_access done");
      mwr(2, 32'h13);
      mwr(2, 32'h2013);
      cfgchk();
      for (i = 0; i < 9; i++) rdchk(i);
      $display("test software_reset done");
      n = 16'($urandom_range(1600, 64));
      mwr(8, 32'h0);
      mwr(7, 32'h0000_07f0);
      mwr(3, 32'h1723_1c00);
      mwr(4, 32'h0000_cb4a);
      mwr(5, {16'hffff, n});
      cfgchk();
      mwr(2, 32'h3);
      for (i = -1; i < 2; i++) rxlen(n + 16'(i), i > 0);
      mwr(2, 32'h0);
      rxlen(n + 16'h1, 1'b0);
      $display("test frame_length done");
      mwr(6, $urandom);
      mwr(2, 32'h3);
      congested <= 1'b1;
      @(posedge hclk);
      settle(1'b1);
      chk({16'h0, pause_frame_quanta}, m[6]);
      pause_ack <= 1'b1;
      @(posedge hclk);
      pause_ack <= 1'b0;
      settle(1'b0);
      congested <= 1'b0;
      @(posedge hclk);
      congested <= 1'b1;
      @(posedge hclk);
      settle(1'b1);
      mwr(2, 32'h0);
      @(posedge hclk);
      settle(1'b0);
      $display("test pause_request done");
      results();
   end
endmodule
`default_nettype wire
